// *** verilog/xbc_defs.svh ***
// constants of the external bus controller: field positions, reset values, counts
`ifndef XBC_DEFS_SVH
`define XBC_DEFS_SVH
`define XBC_WIN_MAX 4
`define XBC_PAGE_LSB 12
`define XBC_SEG_LSB 16
`define XBC_ALE_EXT_CYC 2'h1
`define XBC_REC_CYC 2'h1
`define XBC_SEG_MASK_16M 8'hFF
`define XBC_SEG_MASK_1M 8'h0F
`define XBC_SEG_MASK_256K 8'h03
`define XBC_SEG_MASK_64K 8'h00
`define XBC_RST_CS_N 5'h1F
`define XBC_HIT_DEFAULT 3'h0
`endif

// *** verilog/xbc_pkg.sv ***
// types shared by the external bus controller files
package xbc_pkg;
  // per-region bus characteristics
  typedef struct packed {
    logic ext_en;
    logic mux;
    logic w8;
    logic [3:0] mcycle;
    logic rec_en;
    logic ale_ext;
    logic rw_dly;
    logic rdy_en;
    logic rdy_pol;
    logic cs_en;
  } xbc_buscfg_s;
  // window start in 4 KB pages and size code (4 KB << size)
  typedef struct packed {
    logic [11:0] base;
    logic [3:0] size;
  } xbc_addrsel_s;
  typedef enum logic [1:0] {
    XBC_SPACE_16M,
    XBC_SPACE_1M,
    XBC_SPACE_256K,
    XBC_SPACE_64K
  } xbc_space_e;
  typedef enum logic [2:0] {
    XBC_IDLE,
    XBC_ADDR,
    XBC_DLY,
    XBC_DATA,
    XBC_REC,
    XBC_FLOAT,
    XBC_HOLD
  } xbc_state_e;
endpackage

// *** verilog/xbc_win_decode.sv ***
// address window decoder with fixed priority
`timescale 1ns/1ns
`include "xbc_defs.svh"
module xbc_win_decode #(
  parameter int NWIN = 4
) (
  input wire logic [23:0] addr,
  input xbc_pkg::xbc_addrsel_s [NWIN-1:0] win_sel,
  input xbc_pkg::xbc_buscfg_s [NWIN-1:0] win_cfg,
  input xbc_pkg::xbc_buscfg_s dflt_cfg,
  output logic [2:0] hit,
  output xbc_pkg::xbc_buscfg_s cfg
);
  import xbc_pkg::*;

  function automatic logic win_match(input logic [23:0] a, input xbc_addrsel_s s);
    logic [11:0] keep;
    keep = ~((12'h001 << s.size) - 12'h001);
    return ((a[23:`XBC_PAGE_LSB] ^ s.base) & keep) == 12'h000;
  endfunction

  // higher window index is scanned last, so it overrides lower ones
  always_comb begin
    hit = `XBC_HIT_DEFAULT;
    cfg = dflt_cfg;
    for (int i = 0; i < NWIN; i++) begin
      if (win_cfg[i].ext_en && win_match(addr, win_sel[i])) begin
        hit = 3'(i + 1);
        cfg = win_cfg[i];
      end
    end
  end
endmodule // xbc_win_decode

// *** verilog/xbc_top.sv ***
// external bus controller: window decode, bus cycle sequencing, hold arbitration
`timescale 1ns/1ns
`include "xbc_defs.svh"
module xbc_top #(
  parameter int NWIN = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic single_chip,
  input xbc_pkg::xbc_space_e addr_space,
  input xbc_pkg::xbc_addrsel_s [NWIN-1:0] window_address_select,
  input xbc_pkg::xbc_buscfg_s [NWIN-1:0] window_bus_config,
  input xbc_pkg::xbc_buscfg_s default_bus_config,
  input wire logic chip_select_timing_cfg,
  input wire logic arbitration_enable,
  input wire logic ack_pin_direction,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [23:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic cpu_busy_q,
  output logic cpu_done_q,
  output logic cpu_err_q,
  output logic [15:0] cpu_rdata_q,
  output logic [15:0] demux_address_port_q,
  output logic demux_address_port_oe_q,
  output logic [7:0] seg_address_q,
  output logic [7:0] seg_address_oe_q,
  input wire logic [15:0] data_port_in,
  output logic [15:0] data_port_out_q,
  output logic [1:0] data_port_oe_q,
  output logic ale_q,
  output logic rd_n_q,
  output logic wr_n_q,
  output logic ctrl_oe_q,
  output logic [NWIN:0] chip_select_n_q,
  input wire logic ready_in,
  input wire logic hold_req_n,
  output logic bus_request_out_n_q,
  input wire logic bus_grant_ack_n_in,
  output logic bus_grant_ack_n_out_q,
  output logic bus_grant_ack_oe_q
);
  import xbc_pkg::*;

  if (NWIN < 1 || NWIN > `XBC_WIN_MAX) begin : g_chk
    $error("NWIN must lie between 1 and 4");
  end

  function automatic logic [7:0] seg_mask(input xbc_space_e sp);
    case (sp)
      XBC_SPACE_1M: return `XBC_SEG_MASK_1M;
      XBC_SPACE_256K: return `XBC_SEG_MASK_256K;
      XBC_SPACE_64K: return `XBC_SEG_MASK_64K;
      default: return `XBC_SEG_MASK_16M;
    endcase
  endfunction

  xbc_state_e state_q;
  xbc_buscfg_s cfg_q;
  xbc_buscfg_s dec_cfg;
  logic [2:0] dec_hit;
  logic [NWIN:0] cs_val_q;
  logic cs_late_q;
  logic we_q;
  logic [15:0] wdata_q;
  logic [3:0] wait_q;
  logic [1:0] cnt_q;

  xbc_win_decode #(.NWIN(NWIN)) u_dec (
    .addr(cpu_addr),
    .win_sel(window_address_select),
    .win_cfg(window_bus_config),
    .dflt_cfg(default_bus_config),
    .hit(dec_hit),
    .cfg(dec_cfg)
  );

  // arbitration roles
  wire arb_on = arbitration_enable;
  wire slave = arb_on && ack_pin_direction;
  wire hold_seen = arb_on && !slave && !hold_req_n;
  wire slave_lost = slave && bus_grant_ack_n_in;
  wire owned = !arb_on || (!slave && hold_req_n) || (slave && !bus_grant_ack_n_in);

  // region chip select, default region on bit 0
  wire [NWIN:0] cs_onehot = (NWIN + 1)'(1) << dec_hit;
  wire [NWIN:0] cs_new = dec_cfg.cs_en ? ~cs_onehot : '1;
  // 8-bit regions drive only the low byte lane with write data; a mux address phase drives both lanes
  wire [1:0] cfg_lanes = cfg_q.w8 ? 2'h1 : 2'h3;
  wire rdy_ok = !cfg_q.rdy_en || (ready_in == cfg_q.rdy_pol);
  wire [15:0] rd_word = cfg_q.w8 ? {8'h00, data_port_in[7:0]} : data_port_in;
  wire start = cpu_req && !cpu_busy_q && !cpu_done_q;

  // bus cycle sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= XBC_IDLE;
      cfg_q <= '0;
      we_q <= 1'b0;
      wdata_q <= 16'h0000;
      wait_q <= 4'h0;
      cnt_q <= 2'h0;
      cpu_busy_q <= 1'b0;
      cpu_done_q <= 1'b0;
      cpu_err_q <= 1'b0;
      cpu_rdata_q <= 16'h0000;
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      ctrl_oe_q <= 1'b1;
      demux_address_port_q <= 16'h0000;
      demux_address_port_oe_q <= 1'b0;
      seg_address_q <= 8'h00;
      seg_address_oe_q <= 8'h00;
      data_port_out_q <= 16'h0000;
      data_port_oe_q <= 2'h0;
    end else if (ce) begin
      cpu_done_q <= 1'b0;
      cpu_err_q <= 1'b0;
      case (state_q)
        XBC_IDLE: begin
          if (hold_seen || slave_lost) begin
            // bus is idle here, so a running cycle has always completed
            state_q <= XBC_FLOAT;
          end else if (start && single_chip) begin
            // no external bus: the access is answered with an error
            cpu_done_q <= 1'b1;
            cpu_err_q <= 1'b1;
          end else if (start && owned) begin
            cfg_q <= dec_cfg;
            we_q <= cpu_we;
            wdata_q <= cpu_wdata;
            cpu_busy_q <= 1'b1;
            ale_q <= 1'b1;
            cnt_q <= dec_cfg.ale_ext ? `XBC_ALE_EXT_CYC : 2'h0;
            seg_address_q <= cpu_addr[23:`XBC_SEG_LSB] & seg_mask(addr_space);
            seg_address_oe_q <= seg_mask(addr_space);
            if (dec_cfg.mux) begin
              data_port_out_q <= cpu_addr[15:0];
              data_port_oe_q <= 2'h3;
              demux_address_port_oe_q <= 1'b0;
            end else begin
              demux_address_port_q <= cpu_addr[15:0];
              demux_address_port_oe_q <= 1'b1;
              data_port_oe_q <= 2'h0;
            end
          end
        end
        XBC_ADDR: begin
          if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
          end else begin
            ale_q <= 1'b0;
            // mux read must release the port before the device drives it
            data_port_oe_q <= 2'h0;
            if (cfg_q.rw_dly) begin
              state_q <= XBC_DLY;
            end else begin
              state_q <= XBC_DATA;
              rd_n_q <= we_q;
              wr_n_q <= !we_q;
              data_port_out_q <= wdata_q;
              data_port_oe_q <= we_q ? cfg_lanes : 2'h0;
            end
            wait_q <= cfg_q.mcycle;
          end
        end
        XBC_DLY: begin
          state_q <= XBC_DATA;
          rd_n_q <= we_q;
          wr_n_q <= !we_q;
          data_port_out_q <= wdata_q;
          data_port_oe_q <= we_q ? cfg_lanes : 2'h0;
        end
        XBC_DATA: begin
          if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
          end else if (rdy_ok) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            data_port_oe_q <= 2'h0;
            cpu_busy_q <= 1'b0;
            cpu_done_q <= 1'b1;
            if (!we_q) begin
              cpu_rdata_q <= rd_word;
            end
            cnt_q <= `XBC_REC_CYC;
            state_q <= cfg_q.rec_en ? XBC_REC : XBC_IDLE;
          end
        end
        XBC_REC: begin
          if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
          end else begin
            state_q <= XBC_IDLE;
          end
        end
        XBC_FLOAT: begin
          ctrl_oe_q <= 1'b0;
          demux_address_port_oe_q <= 1'b0;
          seg_address_oe_q <= 8'h00;
          data_port_oe_q <= 2'h0;
          state_q <= XBC_HOLD;
        end
        XBC_HOLD: begin
          if (owned) begin
            ctrl_oe_q <= 1'b1;
            state_q <= XBC_IDLE;
          end
        end
        default: state_q <= XBC_IDLE;
      endcase
      if (state_q == XBC_IDLE && start && owned && !single_chip && !hold_seen && !slave_lost) begin
        state_q <= XBC_ADDR;
      end
    end
  end

  // chip selects: early with the rise of ale_q or one clock cycle later
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chip_select_n_q <= (NWIN + 1)'(`XBC_RST_CS_N);
      cs_val_q <= '1;
      cs_late_q <= 1'b0;
    end else if (ce) begin
      cs_late_q <= 1'b0;
      if (state_q == XBC_IDLE && start && owned && !single_chip && !hold_seen
          && !slave_lost) begin
        cs_val_q <= cs_new;
        if (chip_select_timing_cfg) begin
          chip_select_n_q <= cs_new;
        end else begin
          cs_late_q <= 1'b1;
        end
      end else if (cs_late_q) begin
        chip_select_n_q <= cs_val_q;
      end else if (state_q == XBC_DATA && wait_q == 4'h0 && rdy_ok) begin
        chip_select_n_q <= '1;
      end
    end
  end

  // request and acknowledge pins once enabled; the acknowledge pin is driven only outside slave mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_request_out_n_q <= 1'b1;
      bus_grant_ack_n_out_q <= 1'b1;
      bus_grant_ack_oe_q <= 1'b0;
    end else if (ce) begin
      bus_grant_ack_oe_q <= arb_on && !slave;
      if (!arb_on) begin
        bus_request_out_n_q <= 1'b1;
        bus_grant_ack_n_out_q <= 1'b1;
      end else if (slave) begin
        // keep asking while work is pending or the cycle still runs
        bus_request_out_n_q <= !(cpu_req || cpu_busy_q);
        bus_grant_ack_n_out_q <= 1'b1;
      end else begin
        bus_grant_ack_n_out_q <= !(state_q == XBC_HOLD && !hold_req_n);
        bus_request_out_n_q <= !(state_q == XBC_HOLD && cpu_req);
      end
    end
  end
endmodule // xbc_top

// *** verif/xbc_top_chk.sv ***
// assertion checker for the external bus controller top
`timescale 1ns/1ns
module xbc_top_chk #(
  parameter int NWIN = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic single_chip,
  input xbc_pkg::xbc_space_e addr_space,
  input xbc_pkg::xbc_buscfg_s default_bus_config,
  input wire logic chip_select_timing_cfg,
  input wire logic arbitration_enable,
  input wire logic ack_pin_direction,
  input wire logic cpu_done_q,
  input wire logic cpu_err_q,
  input wire logic demux_address_port_oe_q,
  input wire logic [7:0] seg_address_oe_q,
  input wire logic [1:0] data_port_oe_q,
  input wire logic ale_q,
  input wire logic rd_n_q,
  input wire logic wr_n_q,
  input wire logic ctrl_oe_q,
  input wire logic [NWIN:0] chip_select_n_q,
  input wire logic ready_in,
  input wire logic hold_req_n,
  input wire logic bus_request_out_n_q,
  input wire logic bus_grant_ack_n_out_q,
  input wire logic bus_grant_ack_oe_q
);
  import xbc_pkg::*;
  logic [7:0] seg_mask;
  assign seg_mask = addr_space == XBC_SPACE_16M ? 8'hFF : addr_space == XBC_SPACE_1M ? 8'h0F :
    addr_space == XBC_SPACE_256K ? 8'h03 : 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_strobe;
    !rd_n_q || !wr_n_q;
  endsequence
  sequence s_ack;
    !bus_grant_ack_n_out_q && bus_grant_ack_oe_q;
  endsequence
  a_err_refusal: assert property (cpu_err_q |-> cpu_done_q && single_chip && &chip_select_n_q)
    else $error("error pulse outside refusal");
  a_cs_single: assert property ($onehot0(~chip_select_n_q))
    else $error("several chip selects low");
  a_cs_late: assert property ($rose(ale_q) && !chip_select_timing_cfg |->
    &chip_select_n_q ##1 !(&chip_select_n_q)) else $error("late chip select mistimed");
  a_cs_early: assert property ($rose(ale_q) && chip_select_timing_cfg |->
    !(&chip_select_n_q)) else $error("early chip select missing");
  a_read_float: assert property (!rd_n_q |-> data_port_oe_q == 2'h0)
    else $error("data port driven during read");
  a_ready_wait: assert property (s_strobe ##0 (!chip_select_n_q[0] &&
    default_bus_config.rdy_en && ready_in != default_bus_config.rdy_pol) |=> s_strobe)
    else $error("cycle ended without ready");
  a_seg_lines: assert property (ale_q |-> seg_address_oe_q == seg_mask)
    else $error("segment lines wrong for space");
  a_arb_off: assert property (!arbitration_enable [*3] |->
    bus_request_out_n_q && !bus_grant_ack_oe_q) else $error("arbitration pins active");
  a_slave_input: assert property ((arbitration_enable && ack_pin_direction) [*3] |->
    !bus_grant_ack_oe_q) else $error("ack pin driven in slave mode");
  a_hold_grant: assert property (arbitration_enable && !ack_pin_direction &&
    $fell(hold_req_n) |-> ##[1:40] s_ack) else $error("hold not acknowledged");
  a_hold_float: assert property (s_ack |-> !ctrl_oe_q && data_port_oe_q == 2'h0 &&
    !demux_address_port_oe_q) else $error("bus driven while granted");
endmodule // xbc_top_chk
bind xbc_top xbc_top_chk #(.NWIN(NWIN)) xbc_top_chk_inst (.clk_sys, .sys_rst, .single_chip,
  .addr_space, .default_bus_config, .chip_select_timing_cfg, .arbitration_enable,
  .ack_pin_direction, .cpu_done_q, .cpu_err_q, .demux_address_port_oe_q, .seg_address_oe_q,
  .data_port_oe_q, .ale_q, .rd_n_q, .wr_n_q, .ctrl_oe_q, .chip_select_n_q, .ready_in,
  .hold_req_n, .bus_request_out_n_q, .bus_grant_ack_n_out_q, .bus_grant_ack_oe_q);

// *** verif/xbc_ext_mem.sv ***
// far-side model: one-word external memory with a slow ready line
`timescale 1ns/1ns
module xbc_ext_mem (
  input wire logic clk_sys,
  input wire logic rd_n_q,
  input wire logic wr_n_q,
  input wire logic [15:0] data_port_out_q,
  input wire logic [1:0] data_port_oe_q,
  input wire logic rdy_pol,
  input wire logic [2:0] wait_cyc,
  output logic [15:0] data_port_in,
  output logic ready_in
);
  logic [15:0] word_q = 16'h0000;
  logic [15:0] junk_q = 16'hA5C3;
  logic [3:0] cnt_q = 4'h0;
  // no pull-ups: a released bus flips every cycle
  assign data_port_in = rd_n_q ? junk_q : word_q;
  assign ready_in = cnt_q >= {1'b0, wait_cyc} ? rdy_pol : !rdy_pol;
  always_ff @(posedge clk_sys) begin
    junk_q <= ~junk_q;
    cnt_q <= rd_n_q && wr_n_q ? 4'h0 : cnt_q + 4'h1;
    if (!wr_n_q && data_port_oe_q[0]) word_q[7:0] <= data_port_out_q[7:0];
    if (!wr_n_q && data_port_oe_q[1]) word_q[15:8] <= data_port_out_q[15:8];
  end
endmodule // xbc_ext_mem

// *** verif/tb.sv ***
// self-checking bench for the external bus controller
`timescale 1ns/1ns
module tb;
  import xbc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic [23:0] cpu_addr = 24'h000000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic single_chip = 1'b0;
  xbc_space_e addr_space = XBC_SPACE_16M;
  logic chip_select_timing_cfg = 1'b0;
  logic arbitration_enable = 1'b0;
  logic ack_pin_direction = 1'b0;
  logic bus_grant_ack_n_in = 1'b1;
  logic hold_req_n = 1'b1;
  logic rpol = 1'b0;
  logic [2:0] wcyc = 3'h0;
  // all windows cover 0x010000..0x01FFFF so only priority separates them
  xbc_addrsel_s [3:0] wsel = {4{16'h0104}};
  // window 4 down to window 1, then default; windows start disabled
  xbc_buscfg_s [4:0] rcfg = {13'h0087, 13'h0C09, 13'h0411, 13'h0861, 13'h0005};
  logic cpu_busy_q, cpu_done_q, cpu_err_q, demux_address_port_oe_q, ale_q, rd_n_q, wr_n_q;
  logic ctrl_oe_q, bus_request_out_n_q, bus_grant_ack_n_out_q, bus_grant_ack_oe_q, ready_in;
  logic [15:0] cpu_rdata_q, demux_address_port_q, data_port_in, data_port_out_q;
  logic [7:0] seg_address_q, seg_address_oe_q;
  logic [1:0] data_port_oe_q;
  logic [4:0] chip_select_n_q;
  logic [4:0] cs_seen = 5'h00;
  logic [15:0] last_rd = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [21:0] exp_q[$];
  int failures = 0;
  int comparisons = 0;
  int k;
  integer seed, rv;
  xbc_top #(.NWIN(4)) xbc_top_inst (.clk_sys, .sys_rst, .ce(1'b1), .single_chip, .addr_space,
    .window_address_select(wsel), .window_bus_config(rcfg[4:1]), .default_bus_config(rcfg[0]),
    .chip_select_timing_cfg, .arbitration_enable, .ack_pin_direction, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .cpu_busy_q, .cpu_done_q, .cpu_err_q, .cpu_rdata_q,
    .demux_address_port_q, .demux_address_port_oe_q, .seg_address_q, .seg_address_oe_q,
    .data_port_in, .data_port_out_q, .data_port_oe_q, .ale_q, .rd_n_q, .wr_n_q, .ctrl_oe_q,
    .chip_select_n_q, .ready_in, .hold_req_n, .bus_request_out_n_q, .bus_grant_ack_n_in,
    .bus_grant_ack_n_out_q, .bus_grant_ack_oe_q);
  xbc_ext_mem xbc_ext_mem_inst (.clk_sys, .rd_n_q, .wr_n_q, .data_port_out_q, .data_port_oe_q,
    .rdy_pol(rpol), .wait_cyc(wcyc), .data_port_in, .ready_in);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_rsp(input logic [21:0] e, input logic [21:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t response exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_pin(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t pin exp %b got %b", $time, e, g);
    end
  endtask
  // note the response first; request held until the done pulse
  task automatic acc(input logic we, input int r, input logic [23:0] a);
    if (!we && !single_chip) last_rd = rcfg[r].w8 ? {8'h00, wd[7:0]} : wd;
    exp_q.push_back({single_chip, single_chip ? 5'h00 : 5'(1 << r), last_rd});
    @(posedge clk_sys);
    rpol <= rcfg[r].rdy_pol;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= wd;
    cpu_req <= 1'b1;
    repeat (60) begin
      @(posedge clk_sys);
      if (cpu_done_q === 1'b1) break;
    end
    cpu_req <= 1'b0;
  endtask
  // chip selects are gathered over the whole cycle, judged at the done pulse
  always @(negedge clk_sys) begin
    if (sys_rst) cs_seen = 5'h00;
    else if (cpu_done_q === 1'b1) begin
      chk_rsp(exp_q.pop_front(), {cpu_err_q, cs_seen, cpu_rdata_q});
      cs_seen = 5'h00;
    end else cs_seen = cs_seen | ~chip_select_n_q;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    $display("mismatch %0t timeout", $time);
    complete_run();
  end
  initial begin
    seed = 32'h2971;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_pin(1'b1, bus_grant_ack_n_out_q);
    chk_pin(1'b0, bus_grant_ack_oe_q);
    acc(1'b0, 0, 24'h800000);
    for (k = 0; k <= 4; k++) begin
      if (k > 0) rcfg[k].ext_en <= 1'b1;
      chip_select_timing_cfg <= k[0];
      rv = $random(seed);
      wd = rv[15:0];
      wcyc <= rv[18:16];
      acc(1'b1, k, 24'h010400);
      acc(1'b0, k, 24'h010400);
    end
    for (k = 0; k < 4; k++) begin
      addr_space <= xbc_space_e'(k);
      acc(1'b1, 0, 24'hFFF000);
      chk_rsp(22'(8'hFF >> (k == 0 ? 0 : 2 + 2 * k)), 22'(seg_address_q));
      chk_rsp(22'h00F000, 22'(demux_address_port_q));
      chk_pin(1'b0, cpu_busy_q);
    end
    addr_space <= XBC_SPACE_16M;
    single_chip <= 1'b1;
    @(posedge clk_sys);
    acc(1'b1, 0, 24'h800000);
    single_chip <= 1'b0;
    arbitration_enable <= 1'b1;
    hold_req_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    fork
      acc(1'b1, 0, 24'h800000);
      begin
        repeat (6) @(posedge clk_sys);
        chk_pin(1'b0, bus_request_out_n_q);
        hold_req_n <= 1'b1;
      end
    join
    ack_pin_direction <= 1'b1;
    fork
      acc(1'b1, 0, 24'h800000);
      begin
        repeat (6) @(posedge clk_sys);
        chk_pin(1'b0, bus_request_out_n_q);
        chk_pin(1'b0, ctrl_oe_q);
        bus_grant_ack_n_in <= 1'b0;
      end
    join
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule // tb
